/* File: pkg/mask_gating_defines.svh */
`ifndef MASK_GATING_DEFINES_SVH
`define MASK_GATING_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define MG_ADDR_W 4
`define MG_CTRL_ADDR 4'h0
`define MG_STAT_ADDR 4'h1
`define MG_CTRL_RESET 16'h0000
`define MG_CTRL_WMASK 16'hBFFF
`define MG_RDATA_IDLE 16'h0000
`define MG_STAT_PAD 12'h000
// ----------------------------------------
// field positions
// ----------------------------------------
`define MG_LEVEL_BIT 15
`define MG_OR_C_T 13
`define MG_OR_C_N 12
`define MG_OR_B_T 11
`define MG_OR_B_N 10
`define MG_OR_A_T 9
`define MG_OR_A_N 8
`define MG_AND_N_TO_OR 7
`define MG_AND_T_TO_OR 6
`define MG_AND_C_T 5
`define MG_AND_C_N 4
`define MG_AND_B_T 3
`define MG_AND_B_N 2
`define MG_AND_A_T 1
`define MG_AND_A_N 0
`endif

/* File: pkg/mask_gating_pkg.sv */
package mask_gating_pkg;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [15:0] ctrl_word_t;
    typedef logic [2:0] src_vec_t;
endpackage

/* File: core/gate_term.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// one gate: sources in true or inverted form
// ----------------------------------------
module gate_term #(
    parameter int N = 3,
    parameter bit IS_AND = 1'b1
) (
    // sources and enables
    input wire logic [N-1:0] src_in,
    input wire logic [N-1:0] true_en_in,
    input wire logic [N-1:0] inv_en_in,
    // result
    output logic result_out,
    output logic active_out
);
    // a gate needs at least one source
    if (N < 1) begin : g_bad_n
        $error("gate_term needs at least one source");
    end
    // each enabled term of a source
    wire [N-1:0] t_term = src_in & true_en_in;
    wire [N-1:0] n_term = ~src_in & inv_en_in;
    wire [N-1:0] t_ok = src_in | ~true_en_in;
    wire [N-1:0] n_ok = ~src_in | ~inv_en_in;
    // gate with nothing connected is inactive
    assign active_out = |(true_en_in | inv_en_in);
    assign result_out = IS_AND ? (active_out & (&t_ok) & (&n_ok))
                               : (|t_term) | (|n_term);
endmodule
`default_nettype wire

/* File: core/comparator_mask_gating.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mask_gating_defines.svh"
module comparator_mask_gating (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [`MG_ADDR_W-1:0] addr_in,
    input wire mask_gating_pkg::ctrl_word_t wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output mask_gating_pkg::ctrl_word_t rdata_out,
    // mask sources: bit 0 a, bit 1 b, bit 2 c
    input wire mask_gating_pkg::src_vec_t mask_source_in,
    // comparator path
    input wire logic cmp_in,
    output logic cmp_out,
    output logic blank_out
);
    import mask_gating_pkg::*;
    // ----------------------------------------
    // control register
    // ----------------------------------------
    ctrl_word_t ctrl_r; // mask gating control
    ctrl_word_t ctrl_nxt;
    ctrl_word_t rdata_r;
    ctrl_word_t rdata_nxt;
    // write strobe aimed at the control word
    wire wr_ctrl = wr_in && (addr_in == `MG_CTRL_ADDR);
    // bit 14 never stored
    assign ctrl_nxt = wr_ctrl ? (wdata_in & `MG_CTRL_WMASK) : ctrl_r;
    // named fields
    wire blank_level_select = ctrl_r[`MG_LEVEL_BIT];
    wire or_in_c_true_en = ctrl_r[`MG_OR_C_T];
    wire or_in_c_inv_en = ctrl_r[`MG_OR_C_N];
    wire or_in_b_true_en = ctrl_r[`MG_OR_B_T];
    wire or_in_b_inv_en = ctrl_r[`MG_OR_B_N];
    wire or_in_a_true_en = ctrl_r[`MG_OR_A_T];
    wire or_in_a_inv_en = ctrl_r[`MG_OR_A_N];
    wire and_result_inv_to_or = ctrl_r[`MG_AND_N_TO_OR];
    wire and_result_true_to_or = ctrl_r[`MG_AND_T_TO_OR];
    wire and_in_c_true_en = ctrl_r[`MG_AND_C_T];
    wire and_in_c_inv_en = ctrl_r[`MG_AND_C_N];
    wire and_in_b_true_en = ctrl_r[`MG_AND_B_T];
    wire and_in_b_inv_en = ctrl_r[`MG_AND_B_N];
    wire and_in_a_true_en = ctrl_r[`MG_AND_A_T];
    wire and_in_a_inv_en = ctrl_r[`MG_AND_A_N];
    // ----------------------------------------
    // and gate
    // ----------------------------------------
    wire and_gate_result;
    wire and_active;
    wire [2:0] and_t_en = {and_in_c_true_en, and_in_b_true_en, and_in_a_true_en};
    wire [2:0] and_n_en = {and_in_c_inv_en, and_in_b_inv_en, and_in_a_inv_en};
    // and gate over the three sources
    gate_term #(.N(3), .IS_AND(1'b1)) u_and (
        .src_in(mask_source_in),
        .true_en_in(and_t_en),
        .inv_en_in(and_n_en),
        .result_out(and_gate_result),
        .active_out(and_active)
    );
    // ----------------------------------------
    // or gate: three sources plus and result
    // ----------------------------------------
    wire or_result;
    wire [3:0] or_src = {and_gate_result, mask_source_in};
    wire [3:0] or_t_en = {and_result_true_to_or, or_in_c_true_en,
                          or_in_b_true_en, or_in_a_true_en};
    wire [3:0] or_n_en = {and_result_inv_to_or, or_in_c_inv_en,
                          or_in_b_inv_en, or_in_a_inv_en};
    // or gate over the sources and the and result
    gate_term #(.N(4), .IS_AND(1'b0)) u_or (
        .src_in(or_src),
        .true_en_in(or_t_en),
        .inv_en_in(or_n_en),
        .result_out(or_result),
        .active_out()
    );
    // ----------------------------------------
    // blanking of comparator signal
    // ----------------------------------------
    // level 1 blocks asserted-low, level 0 blocks asserted-high
    wire cmp_asserted = blank_level_select ? ~cmp_in : cmp_in;
    // or result is the blanking qualifier
    assign blank_out = or_result;
    // forced to the deasserted level, which equals the select bit
    assign cmp_out = (or_result && cmp_asserted) ? blank_level_select
                                                 : cmp_in;
    // ----------------------------------------
    // read path
    // ----------------------------------------
    // status: pad, blanked output, blank, and gate active, and result
    wire [15:0] stat_word = {`MG_STAT_PAD, cmp_out, or_result, and_active, and_gate_result};
    // read data are zero except in the cycle after a read strobe
    assign rdata_nxt = !rd_in ? `MG_RDATA_IDLE :
                       (addr_in == `MG_CTRL_ADDR) ? ctrl_r :
                       (addr_in == `MG_STAT_ADDR) ? stat_word : `MG_RDATA_IDLE;
    // ----------------------------------------
    // registers
    // ----------------------------------------
    // control word and registered read data
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_r <= `MG_CTRL_RESET;
            rdata_r <= `MG_RDATA_IDLE;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata_out = rdata_r;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // unimplemented bit 14 never reads as one
    property p_bit14_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        $past(rd_in) |-> rdata_out[14] == 1'b0;
    endproperty
    a_bit14_zero: assert property (p_bit14_zero) else $error("bit 14 read nonzero");
    // a write read straight back returns the masked word
    property p_write_reads_back;
        @(posedge clk_in) disable iff (!rst_b_in)
        (wr_in && addr_in == `MG_CTRL_ADDR) ##1 (rd_in && addr_in == `MG_CTRL_ADDR)
            |=> rdata_out == ($past(wdata_in, 2) & `MG_CTRL_WMASK);
    endproperty
    a_write_reads_back: assert property (p_write_reads_back) else $error("readback mismatch");
    // nothing connected: no blanking, the signal passes
    property p_no_blank_idle;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[13:0] == 14'h0000) |-> (!blank_out && cmp_out == cmp_in);
    endproperty
    a_no_blank_idle: assert property (p_no_blank_idle) else $error("blank with no enables");
    // true c on the or gate blanks
    property p_or_c_true;
        @(posedge clk_in) disable iff (!rst_b_in)
        (or_in_c_true_en && mask_source_in[2]) |-> blank_out;
    endproperty
    a_or_c_true: assert property (p_or_c_true) else $error("c true missed");
    // inverted c on the or gate blanks
    property p_or_c_inv;
        @(posedge clk_in) disable iff (!rst_b_in)
        (or_in_c_inv_en && !mask_source_in[2]) |-> blank_out;
    endproperty
    a_or_c_inv: assert property (p_or_c_inv) else $error("c inv missed");
    // b on the or gate in either form
    property p_or_b;
        @(posedge clk_in) disable iff (!rst_b_in)
        ((or_in_b_true_en && mask_source_in[1]) || (or_in_b_inv_en && !mask_source_in[1]))
            |-> blank_out;
    endproperty
    a_or_b: assert property (p_or_b) else $error("b to or missed");
    // a on the or gate in either form
    property p_or_a;
        @(posedge clk_in) disable iff (!rst_b_in)
        ((or_in_a_true_en && mask_source_in[0]) || (or_in_a_inv_en && !mask_source_in[0]))
            |-> blank_out;
    endproperty
    a_or_a: assert property (p_or_a) else $error("a to or missed");
    // and result on the or gate in either form
    property p_and_to_or;
        @(posedge clk_in) disable iff (!rst_b_in)
        ((and_result_true_to_or && and_gate_result) ||
         (and_result_inv_to_or && !and_gate_result)) |-> blank_out;
    endproperty
    a_and_to_or: assert property (p_and_to_or) else $error("and result missed");
    // c alone in true form on the and gate
    property p_and_c_only;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h20) |-> and_gate_result == mask_source_in[2];
    endproperty
    a_and_c_only: assert property (p_and_c_only) else $error("and c true wrong");
    // inverted c with true b on the and gate
    property p_and_cn_b;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h18) |-> and_gate_result == (!mask_source_in[2] && mask_source_in[1]);
    endproperty
    a_and_cn_b: assert property (p_and_cn_b) else $error("and c inv or b wrong");
    // a blanked signal is held at the deasserted level
    property p_blank_holds;
        @(posedge clk_in) disable iff (!rst_b_in)
        (blank_out && (blank_level_select ? !cmp_in : cmp_in)) |-> cmp_out == blank_level_select;
    endproperty
    a_blank_holds: assert property (p_blank_holds) else $error("asserted level leaked");
    // an unblanked signal passes untouched
    property p_pass_through;
        @(posedge clk_in) disable iff (!rst_b_in)
        !blank_out |-> cmp_out == cmp_in;
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("unblanked signal altered");
    // read data fall back to zero outside the read cycle
    property p_rdata_idle;
        @(posedge clk_in) disable iff (!rst_b_in)
        !$past(rd_in) |-> rdata_out == `MG_RDATA_IDLE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    // control word read back one cycle after the strobe
    property p_ctrl_readback;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_in && addr_in == `MG_CTRL_ADDR) |=> rdata_out == $past(ctrl_r);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("ctrl readback");
    // status word read back one cycle after the strobe
    property p_stat_readback;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_in && addr_in == `MG_STAT_ADDR) |=>
            rdata_out == {`MG_STAT_PAD, $past(cmp_out), $past(blank_out),
                          $past(and_active), $past(and_gate_result)};
    endproperty
    a_stat_readback: assert property (p_stat_readback) else $error("status readback");
    // reads of unmapped places return zero
    property p_unmapped_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        (rd_in && addr_in != `MG_CTRL_ADDR && addr_in != `MG_STAT_ADDR)
            |=> rdata_out == `MG_RDATA_IDLE;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
    // a control write lands with bit 14 dropped
    property p_write_lands;
        @(posedge clk_in) disable iff (!rst_b_in)
        (wr_in && addr_in == `MG_CTRL_ADDR) |=> ctrl_r == ($past(wdata_in) & `MG_CTRL_WMASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");
    // anything but a control write leaves the word alone
    property p_ctrl_holds;
        @(posedge clk_in) disable iff (!rst_b_in)
        !(wr_in && addr_in == `MG_CTRL_ADDR) |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_ctrl_holds: assert property (p_ctrl_holds) else $error("control word changed");
    // an or gate with nothing connected never blanks
    property p_or_inactive;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[`MG_OR_C_T:`MG_AND_T_TO_OR] == '0) |-> !blank_out;
    endproperty
    a_or_inactive: assert property (p_or_inactive) else $error("idle or gate blanks");
    // an and gate with nothing connected stays low
    property p_and_inactive;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[`MG_AND_C_T:`MG_AND_A_N] == '0) |-> (!and_gate_result && !and_active);
    endproperty
    a_and_inactive: assert property (p_and_inactive) else $error("idle and gate high");
    // source b wanted both true and inverted never satisfies the and
    property p_and_contra;
        @(posedge clk_in) disable iff (!rst_b_in)
        (and_in_b_true_en && and_in_b_inv_en) |-> !and_gate_result;
    endproperty
    a_and_contra: assert property (p_and_contra) else $error("contradiction passed");
    // b alone in true form on the and gate
    property p_and_b_true;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h08) |-> and_gate_result == mask_source_in[1];
    endproperty
    a_and_b_true: assert property (p_and_b_true) else $error("and b true wrong");
    // b alone in inverted form on the and gate
    property p_and_b_inv;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h04) |-> and_gate_result == !mask_source_in[1];
    endproperty
    a_and_b_inv: assert property (p_and_b_inv) else $error("and b inv wrong");
    // a alone in true form on the and gate
    property p_and_a_true;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h02) |-> and_gate_result == mask_source_in[0];
    endproperty
    a_and_a_true: assert property (p_and_a_true) else $error("and a true wrong");
    // a alone in inverted form on the and gate
    property p_and_a_inv;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h01) |-> and_gate_result == !mask_source_in[0];
    endproperty
    a_and_a_inv: assert property (p_and_a_inv) else $error("and a inv wrong");
    // c alone in inverted form on the and gate
    property p_and_c_inv;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ctrl_r[5:0] == 6'h10) |-> and_gate_result == !mask_source_in[2];
    endproperty
    a_and_c_inv: assert property (p_and_c_inv) else $error("and c inv wrong");
    // a comparator signal at the deasserted level always passes
    property p_deasserted_passes;
        @(posedge clk_in) disable iff (!rst_b_in)
        (blank_level_select ? cmp_in : !cmp_in) |-> cmp_out == cmp_in;
    endproperty
    a_deasserted_passes: assert property (p_deasserted_passes)
        else $error("idle level altered");
    // blanking only while some connected term is high
    property p_blank_needs_term;
        @(posedge clk_in) disable iff (!rst_b_in)
        blank_out |-> ((or_in_a_true_en && mask_source_in[0]) ||
                       (or_in_a_inv_en && !mask_source_in[0]) ||
                       (or_in_b_true_en && mask_source_in[1]) ||
                       (or_in_b_inv_en && !mask_source_in[1]) ||
                       (or_in_c_true_en && mask_source_in[2]) ||
                       (or_in_c_inv_en && !mask_source_in[2]) ||
                       (and_result_true_to_or && and_gate_result) ||
                       (and_result_inv_to_or && !and_gate_result));
    endproperty
    a_blank_needs_term: assert property (p_blank_needs_term)
        else $error("blank with no term");
    // main scenarios
    c_blank_high: cover property (@(posedge clk_in) blank_out && cmp_in && !blank_level_select);
    c_blank_low: cover property (@(posedge clk_in) blank_out && !cmp_in && blank_level_select);
    c_and_path: cover property (@(posedge clk_in) and_result_true_to_or && and_gate_result);
    c_and_inv_path: cover property (@(posedge clk_in) and_result_inv_to_or && !and_gate_result);
    c_stat_read: cover property (@(posedge clk_in) rd_in && addr_in == `MG_STAT_ADDR);
endmodule
`default_nettype wire

/* File: bench/mask_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// far side: mask sources and comparator
// ----------------------------------------
module mask_side_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // requested levels
    input wire logic [2:0] src_req_in,
    input wire logic cmp_req_in,
    // driven levels
    output logic [2:0] mask_source_out,
    output logic cmp_out
);
    // sources change at a clock edge or at reset, like a synchronised analog path
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask_source_out <= 3'h0;
            cmp_out <= 1'b0;
        end else begin
            mask_source_out <= src_req_in;
            cmp_out <= cmp_req_in;
        end
    end
endmodule
`default_nettype wire

/* File: bench/comparator_mask_gating_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mask_gating_defines.svh"
module comparator_mask_gating_tb;
    import mask_gating_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    ctrl_word_t wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    ctrl_word_t rdata_out;
    src_vec_t mask_source_in;
    logic cmp_in;
    logic cmp_out;
    logic blank_out;
    logic [2:0] src_req = 3'h0;
    logic cmp_req = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    comparator_mask_gating u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .mask_source_in(mask_source_in), .cmp_in(cmp_in), .cmp_out(cmp_out),
        .blank_out(blank_out));
    mask_side_model u_side (.clk_in(clk_in), .rst_b_in(rst_b_in), .src_req_in(src_req),
        .cmp_req_in(cmp_req), .mask_source_out(mask_source_in), .cmp_out(cmp_in));
    // clock at 50 MHz
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // expected {blank, out}: an unconnected gate is inactive
    function automatic logic [1:0] model(logic [15:0] c, logic [2:0] s, logic cmp);
        logic a;
        logic o;
        a = |c[5:0];
        o = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (c[2*k+1] && !s[k]) a = 1'b0;
            if (c[2*k] && s[k]) a = 1'b0;
            o = o | (c[9+2*k] & s[k]) | (c[8+2*k] & ~s[k]);
        end
        o = o | (c[6] & a) | (c[7] & ~a);
        return {o, (o && cmp == !c[15]) ? c[15] : cmp};
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // program a word, then sweep every source and comparator level
    task automatic gating_sweep(input logic [15:0] c);
        logic [15:0] d;
        bus_wr(`MG_CTRL_ADDR, c);
        bus_rd(`MG_CTRL_ADDR, d);
        check(d, c & 16'hBFFF);
        for (int v = 0; v < 16; v++) begin
            @(posedge clk_in);
            src_req <= v[2:0];
            cmp_req <= v[3];
            @(posedge clk_in);
            #1 check({blank_out, cmp_out}, model(c, v[2:0], v[3]));
        end
    endtask
    // reset state, status and unmapped places
    task automatic reset_and_map;
        logic [15:0] d;
        bus_rd(`MG_CTRL_ADDR, d);
        check(d, 16'h0000);
        gating_sweep(16'h0000);
        bus_rd(`MG_STAT_ADDR, d);
        check(d, {12'h000, cmp_in, 3'h0});
        bus_wr(4'hF, 16'hFFFF);
        bus_rd(4'hF, d);
        check(d, 16'h0000);
        bus_rd(`MG_CTRL_ADDR, d);
        check(d, 16'h0000);
    endtask
    // each enable alone, and-side ones routed through either polarity
    task automatic each_enable;
        for (int i = 0; i < 14; i++) begin
            gating_sweep((16'h0001 << i) | (i < 6 ? 16'h0040 : 16'h0000));
            gating_sweep((16'h0001 << i) | (i < 6 ? 16'h8080 : 16'hC000));
        end
        gating_sweep(16'h0076);
        gating_sweep(16'h0058);
        gating_sweep(16'hBF3F);
    endtask
    // write, then two reads with no gap, then a reset in mid-run
    task automatic back_to_back;
        logic [15:0] d;
        @(posedge clk_in);
        src_req <= 3'h4;
        cmp_req <= 1'b1;
        addr_in <= `MG_CTRL_ADDR;
        wdata_in <= 16'h4060;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in);
        addr_in <= `MG_STAT_ADDR;
        #1 check(rdata_out, 16'h0060);
        @(posedge clk_in);
        rd_in <= 1'b0;
        // c high, and gate active and high, blanking, high level held low
        #1 check(rdata_out, 16'h0007);
        check({blank_out, cmp_out}, 16'h0002);
        @(posedge clk_in);
        #1 check(rdata_out, 16'h0000);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check({blank_out, cmp_out}, {1'b0, cmp_in});
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        bus_rd(`MG_CTRL_ADDR, d);
        check(d, 16'h0000);
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog: about twelve times the expected run of some 1200 cycles
    initial begin
        #300000;
        mismatches++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        reset_and_map();
        each_enable();
        back_to_back();
        complete_run();
    end
endmodule
`default_nettype wire
